/* File: design/dsts_pkg.sv */
package dsts_pkg;
	// telegram framing
	localparam logic [7:0] START_CHAR     = 8'h02;
	localparam int         MAX_NET        = 38;
	localparam int         MAX_NODES      = 31;
	localparam int         NODE_W         = 5;
	localparam int         ADDR_BCAST_BIT = 5;
	localparam int         LEN_EXTRA      = 2;
	localparam int         RES_EXTRA      = 3;
	localparam int         HDR_BYTES      = 3;
	localparam int         GAP_CHARS      = 2;
	// character frame
	localparam int         DATA_BITS      = 8;
	localparam logic [3:0] BITS_PAR       = 4'hB;
	localparam logic [3:0] BITS_NOPAR     = 4'hA;
	// timing at a 10 ns core clock
	localparam int         CLK_NS         = 10;
	localparam int         RSP_MAX_US     = 20000;
	localparam int         RSP_MAX_CYC    = RSP_MAX_US * 1000 / CLK_NS;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_GAP  = 3'h1,
		ST_SEND = 3'h2,
		ST_WAIT = 3'h3,
		ST_RECV = 3'h4
	} dsts_state_type;

	// poll outcome codes
	localparam logic [3:0] ERR_NONE   = 4'h0;
	localparam logic [3:0] ERR_NO_TX  = 4'h1;
	localparam logic [3:0] ERR_PARITY = 4'h2;
	localparam logic [3:0] ERR_FRAME  = 4'h3;
	localparam logic [3:0] ERR_BCC    = 4'h4;
	localparam logic [3:0] ERR_RESID  = 4'h5;
	localparam logic [3:0] ERR_LEN    = 4'h6;
	localparam logic [3:0] ERR_ADDR   = 4'h7;
	localparam logic [3:0] ERR_STX    = 4'h8;
	localparam logic [3:0] ERR_CFG    = 4'h9;

	// bits per character, start and stop included
	function automatic logic [3:0] char_bits(input logic par_en);
		return par_en ? BITS_PAR : BITS_NOPAR;
	endfunction : char_bits
endpackage : dsts_pkg

/* File: design/dsts_char_tx.sv */
`timescale 1ns/10ps
module dsts_char_tx (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_bit_tick,
	input  wire logic       i_load,
	input  wire logic [7:0] i_data,
	input  wire logic       i_parity_en,
	output logic            o_line,
	output logic            o_busy
);
	logic [10:0] sh_reg,   sh_next;
	logic [3:0]  cnt_reg,  cnt_next;
	logic        line_reg, line_next;
	logic        busy_reg, busy_next;
	logic        par;

	// frame is loaded whole, then shifted one bit per tick, lsb first
	always_comb begin
		par       = ^i_data;
		sh_next   = sh_reg;
		cnt_next  = cnt_reg;
		line_next = line_reg;
		busy_next = busy_reg;
		if (i_load && !busy_reg) begin
			busy_next = 1'b1;
			cnt_next  = dsts_pkg::char_bits(i_parity_en);
			sh_next   = i_parity_en ? {1'b1, par, i_data, 1'b0}
			                        : {2'b11, i_data, 1'b0};
		end else if (busy_reg && i_bit_tick) begin
			if (cnt_reg != 4'h0) begin
				line_next = sh_reg[0];
				sh_next   = {1'b1, sh_reg[10:1]};
				cnt_next  = cnt_reg - 4'h1;
			end else begin
				busy_next = 1'b0; // stop bit has held one full period
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sh_reg   <= 11'h7FF;
			cnt_reg  <= 4'h0;
			line_reg <= 1'b1;
			busy_reg <= 1'b0;
		end else begin
			sh_reg   <= sh_next;
			cnt_reg  <= cnt_next;
			line_reg <= line_next;
			busy_reg <= busy_next;
		end
	end

	assign o_line = line_reg;
	assign o_busy = busy_reg;

	a_parity_even: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_load && !busy_reg && i_parity_en) |=> (^sh_reg[9:1]) == 1'b0)
		else $error("parity bit does not make ones even");
	a_frame_bits: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(busy_reg) |-> cnt_reg == dsts_pkg::char_bits($past(i_parity_en)))
		else $error("character frame has wrong bit count");
endmodule : dsts_char_tx

/* File: design/dsts_char_rx.sv */
`timescale 1ns/10ps
module dsts_char_rx (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_line,
	input  wire logic [15:0] i_baud_div,
	input  wire logic        i_parity_en,
	output logic             o_start,
	output logic             o_valid,
	output logic [7:0]       o_data,
	output logic             o_par_err,
	output logic             o_frm_err
);
	logic        s1_reg, s2_reg;
	logic [15:0] cnt_reg,  cnt_next;
	logic [3:0]  bitn_reg, bitn_next;
	logic [9:0]  sh_reg,   sh_next;
	logic        busy_reg, busy_next;
	logic        start_reg, start_next;
	logic        valid_reg, valid_next;
	logic [7:0]  data_reg, data_next;
	logic        perr_reg, perr_next;
	logic        ferr_reg, ferr_next;

	// the pin is asynchronous to the core clock
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
		end else begin
			s1_reg <= i_line;
			s2_reg <= s1_reg;
		end
	end

	// sample mid-bit; a start bit that is gone at mid-bit is a glitch
	always_comb begin
		cnt_next   = cnt_reg;
		bitn_next  = bitn_reg;
		sh_next    = sh_reg;
		busy_next  = busy_reg;
		start_next = 1'b0;
		valid_next = 1'b0;
		data_next  = data_reg;
		perr_next  = perr_reg;
		ferr_next  = ferr_reg;
		if (!busy_reg) begin
			if (!s2_reg) begin
				busy_next  = 1'b1;
				start_next = 1'b1;
				bitn_next  = 4'h0;
				cnt_next   = {1'b0, i_baud_div[15:1]};
			end
		end else if (cnt_reg != 16'h0) begin
			cnt_next = cnt_reg - 16'h1;
		end else if (bitn_reg == 4'h0 && s2_reg) begin
			busy_next = 1'b0;
		end else begin
			cnt_next  = i_baud_div - 16'h1;
			bitn_next = bitn_reg + 4'h1;
			if (bitn_reg != 4'h0)
				sh_next = {s2_reg, sh_reg[9:1]};
			if (bitn_reg == dsts_pkg::char_bits(i_parity_en) - 4'h1) begin
				busy_next  = 1'b0;
				valid_next = 1'b1;
				data_next  = i_parity_en ? sh_next[7:0] : sh_next[8:1];
				perr_next  = i_parity_en && (^sh_next[8:0]);
				ferr_next  = !sh_next[9];
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg   <= 16'h0;
			bitn_reg  <= 4'h0;
			sh_reg    <= 10'h3FF;
			busy_reg  <= 1'b0;
			start_reg <= 1'b0;
			valid_reg <= 1'b0;
			data_reg  <= 8'h00;
			perr_reg  <= 1'b0;
			ferr_reg  <= 1'b0;
		end else begin
			cnt_reg   <= cnt_next;
			bitn_reg  <= bitn_next;
			sh_reg    <= sh_next;
			busy_reg  <= busy_next;
			start_reg <= start_next;
			valid_reg <= valid_next;
			data_reg  <= data_next;
			perr_reg  <= perr_next;
			ferr_reg  <= ferr_next;
		end
	end

	assign o_start   = start_reg;
	assign o_valid   = valid_reg;
	assign o_data    = data_reg;
	assign o_par_err = perr_reg;
	assign o_frm_err = ferr_reg;
endmodule : dsts_char_rx

/* File: design/dsts_host.sv */
`timescale 1ns/10ps
module dsts_host #(
	parameter int RSP_MAX_CYC = dsts_pkg::RSP_MAX_CYC
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_line_in,
	output logic             o_line_out,
	output logic             o_line_oe_n,
	input  wire logic [15:0] i_baud_div,
	input  wire logic        i_parity_en,
	input  wire logic [4:0]  i_pzd_words,
	input  wire logic [4:0]  i_pkw_words,
	input  wire logic        i_wr_en,
	input  wire logic [5:0]  i_wr_idx,
	input  wire logic [7:0]  i_wr_data,
	input  wire logic [5:0]  i_rd_idx,
	output logic [7:0]       o_rd_data,
	input  wire logic        i_poll,
	input  wire logic [4:0]  i_node,
	input  wire logic        i_bcast,
	output logic             o_busy,
	output logic             o_done,
	output logic [3:0]       o_err,
	output logic [30:0]      o_no_tx
);
	dsts_pkg::dsts_state_type state_reg, state_next;
	logic [5:0]  n_reg,     n_next;
	logic [4:0]  node_reg,  node_next;
	logic        bc_reg,    bc_next;
	logic        par_reg,   par_next;
	logic [5:0]  idx_reg,   idx_next;
	logic [7:0]  bcc_reg,   bcc_next;
	logic [4:0]  gap_reg,   gap_next;
	logic [20:0] rsp_reg,   rsp_next;
	logic [10:0] res_reg,   res_next;
	logic        oe_n_reg,  oe_n_next;
	logic        done_reg,  done_next;
	logic [3:0]  err_reg,   err_next;
	logic [30:0] notx_reg,  notx_next;
	logic        busy_reg,  busy_next;
	logic        load_q_reg;
	logic [15:0] div_reg,   div_next;
	logic        tick_reg,  tick_next;
	logic [7:0]  rd_reg;
	logic [7:0]  req_mem [0:dsts_pkg::MAX_NET-1];
	logic [7:0]  rsp_mem [0:dsts_pkg::MAX_NET-1];
	logic        tx_load, tx_busy, tx_line;
	logic [7:0]  tx_byte;
	logic        rx_start, rx_valid, rx_perr, rx_ferr;
	logic [7:0]  rx_data;
	logic [6:0]  n_cfg;
	logic [3:0]  bits;
	logic [10:0] res_lim;
	logic        wr_rsp;

	// byte at position idx of an outgoing telegram
	function automatic logic [7:0] frame_byte(input logic [5:0] idx,
		input logic [5:0] n, input logic [4:0] node, input logic bc,
		input logic [7:0] bcc, input logic [7:0] net);
		logic [7:0] addr;
		addr = {2'b00, bc, node};
		if (idx == 6'h0)
			return dsts_pkg::START_CHAR;
		else if (idx == 6'h1)
			return 8'(n + 6'(dsts_pkg::LEN_EXTRA));
		else if (idx == 6'h2)
			return addr;
		else if (idx == n + 6'(dsts_pkg::HDR_BYTES))
			return bcc;
		else
			return net;
	endfunction : frame_byte

	// bit clock enable from a free running divider
	always_comb begin
		tick_next = (div_reg == 16'h0);
		div_next  = tick_next ? i_baud_div - 16'h1 : div_reg - 16'h1;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_reg  <= 16'h0;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			tick_reg <= tick_next;
		end
	end

	// request and response byte stores; user reads are registered
	// the user writes parameter words first, then process words
	always_ff @(posedge i_core_clk) begin
		if (i_wr_en && i_wr_idx < 6'(dsts_pkg::MAX_NET))
			req_mem[i_wr_idx] <= i_wr_data;
		if (wr_rsp)
			rsp_mem[idx_reg - 6'(dsts_pkg::HDR_BYTES)] <= rx_data;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			rd_reg <= 8'h00;
		else if (i_rd_idx < 6'(dsts_pkg::MAX_NET))
			rd_reg <= rsp_mem[i_rd_idx];
		else
			rd_reg <= 8'h00;
	end

	assign n_cfg   = 7'({2'b00, i_pzd_words} + {2'b00, i_pkw_words}) << 1;
	assign bits    = dsts_pkg::char_bits(par_reg);
	assign res_lim = 11'((3 * (int'(n_reg) + dsts_pkg::RES_EXTRA)
	                 * int'(bits)) / 2 + int'(bits));
	assign tx_byte = frame_byte(idx_reg, n_reg, node_reg, bc_reg, bcc_reg,
	                            req_mem[idx_reg - 6'(dsts_pkg::HDR_BYTES)]);
	assign tx_load = (state_reg == dsts_pkg::ST_SEND) && !tx_busy
	                 && !load_q_reg
	                 && idx_reg <= n_reg + 6'(dsts_pkg::HDR_BYTES);
	assign wr_rsp  = (state_reg == dsts_pkg::ST_RECV) && rx_valid
	                 && idx_reg >= 6'(dsts_pkg::HDR_BYTES)
	                 && idx_reg < n_reg + 6'(dsts_pkg::HDR_BYTES);

	// poll sequencer: gap, request, wait, reply check
	always_comb begin
		state_next = state_reg;
		n_next     = n_reg;
		node_next  = node_reg;
		bc_next    = bc_reg;
		par_next   = par_reg;
		idx_next   = idx_reg;
		bcc_next   = bcc_reg;
		gap_next   = gap_reg;
		rsp_next   = rsp_reg;
		res_next   = res_reg;
		oe_n_next  = oe_n_reg;
		done_next  = 1'b0;
		err_next   = err_reg;
		notx_next  = notx_reg;
		case (state_reg)
			dsts_pkg::ST_IDLE: begin
				if (i_poll) begin
					if (n_cfg > 7'(dsts_pkg::MAX_NET)) begin
						done_next = 1'b1;
						err_next  = dsts_pkg::ERR_CFG;
					end else begin
						// length is frozen for the whole poll
						n_next     = n_cfg[5:0];
						node_next  = i_node;
						bc_next    = i_bcast;
						par_next   = i_parity_en;
						gap_next   = 5'h0;
						oe_n_next  = 1'b0;
						state_next = dsts_pkg::ST_GAP;
					end
				end
			end
			dsts_pkg::ST_GAP: begin
				// line held idle high for two whole characters
				if (gap_reg == 5'(dsts_pkg::GAP_CHARS * int'(bits))) begin
					idx_next   = 6'h0;
					bcc_next   = 8'h00;
					state_next = dsts_pkg::ST_SEND;
				end else if (tick_reg) begin
					gap_next = gap_reg + 5'h1;
				end
			end
			dsts_pkg::ST_SEND: begin
				if (tx_load) begin
					idx_next = idx_reg + 6'h1;
					bcc_next = bcc_reg ^ tx_byte;
				end else if (!tx_busy && !load_q_reg) begin
					idx_next = 6'h0;
					rsp_next = 21'h0;
					bcc_next = 8'h00;
					if (bc_reg) begin
						oe_n_next  = 1'b1;
						done_next  = 1'b1;
						err_next   = dsts_pkg::ERR_NONE;
						state_next = dsts_pkg::ST_IDLE;
					end else begin
						oe_n_next  = 1'b1;
						state_next = dsts_pkg::ST_WAIT;
					end
				end
			end
			dsts_pkg::ST_WAIT: begin
				if (rx_start) begin
					res_next   = 11'h0;
					state_next = dsts_pkg::ST_RECV;
				end else if (rsp_reg == 21'(RSP_MAX_CYC - 1)) begin
					notx_next[node_reg] = 1'b1;
					err_next   = dsts_pkg::ERR_NO_TX;
					done_next  = 1'b1;
					state_next = dsts_pkg::ST_IDLE;
				end else begin
					rsp_next = rsp_reg + 21'h1;
				end
			end
			dsts_pkg::ST_RECV: begin
				if (tick_reg)
					res_next = res_reg + 11'h1;
				if (res_reg > res_lim) begin
					err_next   = dsts_pkg::ERR_RESID;
					done_next  = 1'b1;
					state_next = dsts_pkg::ST_IDLE;
				end else if (rx_valid) begin
					idx_next   = idx_reg + 6'h1;
					bcc_next   = bcc_reg ^ rx_data;
					done_next  = 1'b1;
					state_next = dsts_pkg::ST_IDLE;
					if (rx_perr)
						err_next = dsts_pkg::ERR_PARITY;
					else if (rx_ferr)
						err_next = dsts_pkg::ERR_FRAME;
					else if (idx_reg == 6'h0
					         && rx_data != dsts_pkg::START_CHAR)
						err_next = dsts_pkg::ERR_STX;
					else if (idx_reg == 6'h1 && rx_data
					         != 8'(n_reg + 6'(dsts_pkg::LEN_EXTRA)))
						err_next = dsts_pkg::ERR_LEN;
					else if (idx_reg == 6'h2
					         && rx_data != {3'b000, node_reg})
						err_next = dsts_pkg::ERR_ADDR;
					else if (idx_reg == n_reg + 6'(dsts_pkg::HDR_BYTES)) begin
						if (rx_data != bcc_reg)
							err_next = dsts_pkg::ERR_BCC;
						else begin
							err_next = dsts_pkg::ERR_NONE;
							notx_next[node_reg] = 1'b0;
						end
					end else begin
						done_next  = 1'b0;
						state_next = dsts_pkg::ST_RECV;
					end
				end
			end
			default: begin
				state_next = dsts_pkg::ST_IDLE;
				oe_n_next  = 1'b1;
			end
		endcase
		// busy is registered so the port comes straight from a flop
		busy_next = (state_next != dsts_pkg::ST_IDLE);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg  <= dsts_pkg::ST_IDLE;
			n_reg      <= 6'h0;
			node_reg   <= 5'h0;
			bc_reg     <= 1'b0;
			par_reg    <= 1'b0;
			idx_reg    <= 6'h0;
			bcc_reg    <= 8'h00;
			gap_reg    <= 5'h0;
			rsp_reg    <= 21'h0;
			res_reg    <= 11'h0;
			oe_n_reg   <= 1'b1;
			done_reg   <= 1'b0;
			err_reg    <= dsts_pkg::ERR_NONE;
			notx_reg   <= 31'h0;
			busy_reg   <= 1'b0;
			load_q_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			n_reg      <= n_next;
			node_reg   <= node_next;
			bc_reg     <= bc_next;
			par_reg    <= par_next;
			idx_reg    <= idx_next;
			bcc_reg    <= bcc_next;
			gap_reg    <= gap_next;
			rsp_reg    <= rsp_next;
			res_reg    <= res_next;
			oe_n_reg   <= oe_n_next;
			done_reg   <= done_next;
			err_reg    <= err_next;
			notx_reg   <= notx_next;
			busy_reg   <= busy_next;
			load_q_reg <= tx_load;
		end
	end

	dsts_char_tx u_tx (
		.i_core_clk  (i_core_clk),
		.i_rst_n     (i_rst_n),
		.i_bit_tick  (tick_reg),
		.i_load      (tx_load),
		.i_data      (tx_byte),
		.i_parity_en (par_reg),
		.o_line      (tx_line),
		.o_busy      (tx_busy)
	);

	dsts_char_rx u_rx (
		.i_core_clk  (i_core_clk),
		.i_rst_n     (i_rst_n),
		.i_line      (i_line_in),
		.i_baud_div  (i_baud_div),
		.i_parity_en (par_reg),
		.o_start     (rx_start),
		.o_valid     (rx_valid),
		.o_data      (rx_data),
		.o_par_err   (rx_perr),
		.o_frm_err   (rx_ferr)
	);

	assign o_line_out  = tx_line;
	assign o_line_oe_n = oe_n_reg;
	assign o_rd_data   = rd_reg;
	assign o_busy      = busy_reg;
	assign o_done      = done_reg;
	assign o_err       = err_reg;
	assign o_no_tx     = notx_reg;

	a_gap_before_stx: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(tx_load && idx_reg == 6'h0) |-> $past(state_reg) == dsts_pkg::ST_GAP)
		else $error("start character sent without idle gap");
	a_stx_first: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(tx_load && idx_reg == 6'h0) |-> tx_byte == dsts_pkg::START_CHAR)
		else $error("telegram does not open with start character");
	a_len_byte: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(tx_load && idx_reg == 6'h1) |-> tx_byte == 8'(n_reg + 6'h2))
		else $error("length byte is not n plus 2");
	a_net_limit: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(state_reg != dsts_pkg::ST_IDLE) |-> n_reg <= 6'h26)
		else $error("net byte count above limit");
	a_half_duplex: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(state_reg == dsts_pkg::ST_WAIT || state_reg == dsts_pkg::ST_RECV)
		|-> oe_n_reg)
		else $error("host drives line while awaiting reply");
	a_no_tx_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(state_reg == dsts_pkg::ST_WAIT && !rx_start
		 && rsp_reg == 21'(RSP_MAX_CYC - 1))
		|=> o_no_tx[$past(node_reg)] && o_err == 4'h1 && o_done)
		else $error("missing reply not flagged");
	a_no_tx_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(|($past(notx_reg) & ~notx_reg)) |-> done_reg && err_reg == 4'h0)
		else $error("no-reply flag cleared without clean reply");
	a_bcast_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(state_reg == dsts_pkg::ST_SEND && bc_reg)
		|=> state_reg != dsts_pkg::ST_WAIT)
		else $error("host awaits reply to broadcast");
endmodule : dsts_host

/* File: sim/dsts_drive_model.sv */
`timescale 1ns/10ps
// behavioural drive: answers only clean telegrams sent to its own node
module dsts_drive_model #(
	parameter logic [4:0] NODE = 5'h03,
	parameter int         TRIP_CYC = 20000
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_line,
	input  wire logic [15:0] i_baud_div,
	input  wire logic        i_parity_en,
	input  wire logic [6:0]  i_n,
	input  wire logic [15:0] i_delay,
	input  wire logic        i_bad_bcc,
	output logic             o_line,
	output logic             o_en
);
	logic [7:0] rq [0:47];
	int         rep_cnt = 0;
	int         acc_cnt = 0;
	int         seen_acc = 0;
	int         quiet = 0;
	int         cyc = 0;
	logic       tripped;

	// free cycle count for the residual run time check
	always @(posedge i_core_clk) cyc <= cyc + 1;

	// trip when valid telegrams stop; zero disables the watchdog
	always @(posedge i_core_clk) begin
		if (acc_cnt != seen_acc || TRIP_CYC == 0) begin
			seen_acc <= acc_cnt;
			quiet <= 0;
		end else if (acc_cnt > 0 && quiet < TRIP_CYC) begin
			quiet <= quiet + 1;
		end
	end
	assign tripped = (TRIP_CYC != 0) && (quiet >= TRIP_CYC);

	// one character sampled mid-bit; parity and stop faults mark it bad
	task automatic rx(output logic [7:0] d, inout logic bad);
		logic p;
		while (i_line !== 1'b0) @(posedge i_core_clk);
		repeat (i_baud_div / 2) @(posedge i_core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (i_baud_div) @(posedge i_core_clk);
			d[i] = i_line;
		end
		if (i_parity_en) begin
			repeat (i_baud_div) @(posedge i_core_clk);
			p = i_line;
			if (^{d, p}) bad = 1'b1;
		end
		repeat (i_baud_div) @(posedge i_core_clk);
		if (i_line !== 1'b1) bad = 1'b1;
	endtask : rx

	// frame: start, data lsb first, even parity from the byte alone, stop
	task automatic tx(input logic [7:0] d);
		logic [10:0] f;
		f = {1'b1, ^d, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			if (i == 9 && !i_parity_en) continue;
			o_line <= f[i];
			repeat (i_baud_div) @(posedge i_core_clk);
		end
	endtask : tx

	initial begin
		logic [7:0] d;
		logic [7:0] x;
		logic       bad;
		int         run;
		int         t0;
		o_line = 1'b1;
		o_en = 1'b0;
		forever begin
			// a start bit counts only after two idle character times
			run = 0;
			forever begin
				@(posedge i_core_clk);
				if (i_line === 1'b0 && run >= (i_parity_en ? 22 : 20) * i_baud_div) break;
				run = (i_line === 1'b1) ? run + 1 : 0;
			end
			bad = 1'b0;
			rx(d, bad);
			if (d != 8'h02) continue;
			rq[0] = d;
			x = d;
			t0 = cyc;
			for (int k = 1; k < 4 + i_n; k++) begin
				rx(d, bad);
				rq[k] = d;
				if (k == 1 && d != 8'(i_n + 2)) begin
					bad = 1'b1;
					break;
				end
				if (k < 3 + i_n) x ^= d;
			end
			if (cyc - t0 > (3 * (i_n + 3) * (i_parity_en ? 11 : 10) / 2
			    + (i_parity_en ? 11 : 10)) * i_baud_div) bad = 1'b1;
			if (bad || x != d) continue;
			acc_cnt++;
			if (rq[2][5] || rq[2][4:0] != NODE) continue;
			repeat (i_delay) @(posedge i_core_clk);
			o_en <= 1'b1;
			x = 8'h00;
			for (int k = 0; k < 4 + i_n; k++) begin
				d = (k == 0) ? 8'h02 : (k == 1) ? 8'(i_n + 2) : (k == 2) ? {3'h0, NODE} : ~rq[k];
				if (k == 3 + i_n) d = x ^ {7'h00, i_bad_bcc};
				x ^= d;
				tx(d);
			end
			o_en <= 1'b0;
			rep_cnt++;
		end
	end
endmodule : dsts_drive_model

/* File: sim/dsts_host_tb.sv */
`timescale 1ns/10ps
// poll bench: each test task but t_cfg runs one exchange against the drive model; the t_cfg poll is refused before any byte is sent
module dsts_host_tb;
	logic        clk, rst_n, host_out, host_oe_n, drv_out, drv_en, bus;
	logic        par, wr_en, poll, bcast, busy, done, bad_bcc;
	logic [4:0]  process_word_section, parameter_word_section, node;
	logic [5:0]  wr_idx, rd_idx;
	logic [7:0]  wr_data, rd_data;
	logic [3:0]  err;
	logic [30:0] no_tx;
	logic [15:0] delay;
	int          err_count = 0;
	int          tests_run = 0;

	// released bus floats high through its pull-up
	assign bus = !host_oe_n ? host_out : (drv_en ? drv_out : 1'b1);

	dsts_host #(.RSP_MAX_CYC(2000)) dut (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_line_in(bus), .o_line_out(host_out), .o_line_oe_n(host_oe_n),
		.i_baud_div(16'h0004), .i_parity_en(par), .i_pzd_words(process_word_section),
		.i_pkw_words(parameter_word_section), .i_wr_en(wr_en), .i_wr_idx(wr_idx),
		.i_wr_data(wr_data), .i_rd_idx(rd_idx), .o_rd_data(rd_data),
		.i_poll(poll), .i_node(node), .i_bcast(bcast), .o_busy(busy),
		.o_done(done), .o_err(err), .o_no_tx(no_tx));

	dsts_drive_model m_drv (.i_core_clk(clk), .i_line(bus),
		.i_baud_div(16'h0004), .i_parity_en(par),
		.i_n({1'b0, process_word_section, 1'b0} + {1'b0, parameter_word_section, 1'b0}), .i_delay(delay),
		.i_bad_bcc(bad_bcc), .o_line(drv_out), .o_en(drv_en));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	// first byte is the start value on purpose, to sit inside net data
	function automatic logic [7:0] data_of(input int k);
		return 8'(8'h02 + 8'h31 * k);
	endfunction : data_of

	task automatic do_poll(input logic [4:0] nd, input logic bc);
		int k;
		@(negedge clk);
		node = nd;
		bcast = bc;
		poll = 1'b1;
		@(negedge clk);
		poll = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 8000) begin
			@(negedge clk);
			k++;
		end
		if (k == 8000) check(32'h0, 32'h1);
		check(32'(busy), 32'h0);
	endtask : do_poll

	task automatic t_good(input logic p, input logic [4:0] w0, input logic [4:0] w1, input logic [15:0] dl);
		int         n;
		logic [7:0] x;
		logic [7:0] e;
		@(negedge clk);
		par = p;
		parameter_word_section = w0;
		process_word_section = w1;
		delay = dl;
		n = 2 * (w0 + w1);
		for (int k = 0; k < n; k++) begin
			@(negedge clk);
			wr_en = 1'b1;
			wr_idx = 6'(k);
			wr_data = data_of(k);
		end
		@(negedge clk);
		wr_en = 1'b0;
		do_poll(5'h03, 1'b0);
		check(32'(err), 32'h0);
		check(32'(no_tx[3]), 32'h0);
		x = 8'h00;
		for (int k = 0; k < n + 4; k++) begin
			e = (k == 0) ? 8'h02 : (k == 1) ? 8'(n + 2) : (k == 2) ? 8'h03 : (k == n + 3) ? x : data_of(k - 3);
			check(32'(m_drv.rq[k]), 32'(e));
			x ^= e;
		end
		for (int k = 0; k < n; k++) begin
			@(negedge clk);
			rd_idx = 6'(k);
			@(negedge clk);
			e = ~data_of(k);
			check(32'(rd_data), 32'(e));
		end
	endtask : t_good

	// no reply in time, either wrong node or a drive that is too slow
	task automatic t_silent(input logic [4:0] nd, input logic [15:0] dl);
		@(negedge clk);
		delay = dl;
		do_poll(nd, 1'b0);
		check(32'(err), 32'h1);
		check(32'(no_tx[nd]), 32'h1);
		repeat (3000) @(negedge clk);
	endtask : t_silent

	task automatic t_bad_bcc;
		@(negedge clk);
		bad_bcc = 1'b1;
		delay = 16'h0064;
		do_poll(5'h03, 1'b0);
		check(32'(err), 32'h4);
		check(32'(no_tx[3]), 32'h0);
		check(32'(no_tx[7]), 32'h1);
		bad_bcc = 1'b0;
	endtask : t_bad_bcc

	task automatic t_bcast;
		int a;
		int r;
		a = m_drv.acc_cnt;
		r = m_drv.rep_cnt;
		do_poll(5'h03, 1'b1);
		repeat (10) @(negedge clk);
		check(32'(err), 32'h0);
		check(32'(m_drv.acc_cnt), 32'(a + 1));
		check(32'(m_drv.rep_cnt), 32'(r));
		check(32'(m_drv.rq[2]), 32'h23);
	endtask : t_bcast

	task automatic t_cfg;
		int a;
		@(negedge clk);
		parameter_word_section = 5'h00;
		process_word_section = 5'h14;
		a = m_drv.acc_cnt;
		do_poll(5'h03, 1'b0);
		check(32'(err), 32'h9);
		repeat (300) @(negedge clk);
		check(32'(m_drv.acc_cnt), 32'(a));
		check(32'(m_drv.tripped), 32'h0);
	endtask : t_cfg

	initial begin
		rst_n = 1'b0;
		par = 1'b1;
		process_word_section = 5'h01;
		parameter_word_section = 5'h00;
		wr_en = 1'b0;
		wr_idx = 6'h00;
		wr_data = 8'h00;
		rd_idx = 6'h00;
		poll = 1'b0;
		node = 5'h00;
		bcast = 1'b0;
		bad_bcc = 1'b0;
		delay = 16'h0064;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		t_good(1'b1, 5'h00, 5'h01, 16'h0064);
		t_silent(5'h07, 16'h0064);
		t_silent(5'h03, 16'h08FC);
		t_good(1'b0, 5'h01, 5'h01, 16'h05DC);
		t_bad_bcc();
		t_bcast();
		t_cfg();
		give_verdict();
	end

	// a hang costs a mismatch and ends the run the usual way
	initial begin
		#600000;
		err_count++;
		give_verdict();
	end
endmodule : dsts_host_tb
